//--- verilog/mtor_defs.vh
// constants for the modem timing and option register bank
`ifndef MTOR_DEFS_VH
`define MTOR_DEFS_VH

// ****************************************
// register numbers
// ****************************************
`define MTOR_REG_HANGUP 8'h0a
`define MTOR_REG_TONE 8'h0b
`define MTOR_REG_GUARD 8'h0c
`define MTOR_REG_RSVD_A 8'h0d
`define MTOR_REG_OPTIONS 8'h0e
`define MTOR_REG_RSVD_B 8'h0f
`define MTOR_REG_RSVD_C 8'h10
`define MTOR_REG_RSVD_D 8'h11
`define MTOR_REG_ANS_WAIT 8'h12
`define MTOR_REG_POLL 8'h13

// ****************************************
// reset values
// ****************************************
`define MTOR_RST_HANGUP 8'h07
`define MTOR_RST_TONE 8'h0a
`define MTOR_RST_GUARD 8'h02
`define MTOR_RST_OPTIONS 8'h85
`define MTOR_RST_ANS_WAIT 8'h1e
`define MTOR_RST_POLL 8'h02
`define MTOR_RST_ESC_CHAR 8'h2b

// ****************************************
// general option fields
// ****************************************
`define MTOR_OPT_ECHO 0
`define MTOR_OPT_QUIET 1
`define MTOR_OPT_WORDS 2
`define MTOR_OPT_HEX 3
`define MTOR_OPT_ORIG 7
`define MTOR_OPT_WMASK 8'h8f

// ****************************************
// ranges
// ****************************************
`define MTOR_HANGUP_MIN 8'h01
`define MTOR_TONE_MIN 8'h05
`define MTOR_TONE_MAX 8'h19
`define MTOR_ESC_LIMIT 8'h7f
`define MTOR_ESC_COUNT 2'h3

// ****************************************
// timing
// ****************************************
`define MTOR_CLK_NS 10
`define MTOR_MS_NS 1000000
`define MTOR_MS_CYCLES (`MTOR_MS_NS / `MTOR_CLK_NS)
`define MTOR_HANGUP_UNIT_MS 100
`define MTOR_TONE_UNIT_MS 10
`define MTOR_GUARD_UNIT_MS 14'h0032
`define MTOR_ANS_UNIT_MS 1000
`define MTOR_POLL_UNIT_MS 100

`endif

//--- verilog/mtor_div.v
// free-running divider giving a one-cycle enable pulse
`timescale 1ns/1ns
module mtor_div #(
  parameter DIV = 100000
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // enable out
  output reg tick_o
);
  localparam integer LAST_I = DIV - 1;
  localparam [23:0] LAST = LAST_I[23:0];
  reg [23:0] cnt;

  always @(posedge clock_i) begin
    if (rst_i) begin
      cnt <= 24'h000000;
      tick_o <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= 24'h000000;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 24'h000001;
      tick_o <= 1'b0;
    end
  end
endmodule // mtor_div

//--- verilog/mtor_delay.v
// restartable delay counted in steps of whole milliseconds
`timescale 1ns/1ns
module mtor_delay #(
  parameter UNIT_MS = 100
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // timebase
  input wire ms_tick_i,
  // control
  input wire start_i,
  input wire stop_i,
  input wire [7:0] len_i,
  // status
  output reg busy_o,
  output reg done_o
);
  localparam integer LAST_I = UNIT_MS - 1;
  localparam [15:0] LAST = LAST_I[15:0];
  reg [7:0] steps;
  reg [15:0] sub;

  // start reloads even while busy, so a re-trigger restarts the wait
  always @(posedge clock_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      steps <= 8'h00;
      sub <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (stop_i) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        sub <= 16'h0000;
        steps <= len_i;
        busy_o <= (len_i != 8'h00);
        done_o <= (len_i == 8'h00);
      end else if (busy_o && ms_tick_i) begin
        if (sub == LAST) begin
          sub <= 16'h0000;
          if (steps == 8'h01) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end else begin
            steps <= steps - 8'h01;
          end
        end else begin
          sub <= sub + 16'h0001;
        end
      end
    end
  end
endmodule // mtor_delay

//--- verilog/mtor_bank.v
// modem timing and general option register bank with its timers
`timescale 1ns/1ns
`include "mtor_defs.vh"
module mtor_bank #(
  parameter MS_CYCLES = `MTOR_MS_CYCLES,
  parameter HANGUP_UNIT_MS = `MTOR_HANGUP_UNIT_MS,
  parameter TONE_UNIT_MS = `MTOR_TONE_UNIT_MS,
  parameter ANS_UNIT_MS = `MTOR_ANS_UNIT_MS,
  parameter POLL_UNIT_MS = `MTOR_POLL_UNIT_MS
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // register access from the command interpreter
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // call commands and line carrier pin
  input wire answer_call_cmd_i,
  input wire originate_call_cmd_i,
  input wire in_call_i,
  input wire carrier_i,
  // serial characters from the host
  input wire rx_valid_i,
  input wire [7:0] rx_char_i,
  input wire online_i,
  input wire [7:0] escape_char_i,
  // tone dialling
  input wire dial_valid_i,
  input wire [3:0] dial_digit_i,
  output reg dial_ready_o,
  output reg tone_on_o,
  output reg [3:0] tone_digit_o,
  // status monitor
  input wire status_monitor_cmd_i,
  output reg poll_o,
  // call events and echo path
  output reg on_hook_o,
  output reg carrier_o,
  output reg escape_o,
  output reg echo_valid_o,
  output reg [7:0] echo_char_o,
  // option levels
  output reg echo_en_o,
  output reg result_quiet_o,
  output reg word_resp_o,
  output reg hex_readout_o,
  output reg originate_o
);
  // ****************************************
  // registers
  // ****************************************
  reg [7:0] hangup_delay;
  reg [7:0] tone_digit_duration;
  reg [7:0] escape_guard_time;
  reg [7:0] general_options;
  reg [7:0] answer_carrier_wait;
  reg [7:0] status_poll_interval;
  reg [7:0] next_rdata;
  wire wr_hangup = reg_wr_i && (reg_addr_i == `MTOR_REG_HANGUP);
  wire wr_tone = reg_wr_i && (reg_addr_i == `MTOR_REG_TONE);
  wire wr_guard = reg_wr_i && (reg_addr_i == `MTOR_REG_GUARD);
  wire wr_opts = reg_wr_i && (reg_addr_i == `MTOR_REG_OPTIONS);
  wire wr_ans = reg_wr_i && (reg_addr_i == `MTOR_REG_ANS_WAIT);
  wire wr_poll = reg_wr_i && (reg_addr_i == `MTOR_REG_POLL);
  // out-of-range values are clamped so the timers never see them
  always @(posedge clock_i) begin
    if (rst_i) begin
      hangup_delay <= `MTOR_RST_HANGUP;
      tone_digit_duration <= `MTOR_RST_TONE;
      escape_guard_time <= `MTOR_RST_GUARD;
      general_options <= `MTOR_RST_OPTIONS;
      answer_carrier_wait <= `MTOR_RST_ANS_WAIT;
      status_poll_interval <= `MTOR_RST_POLL;
    end else begin
      if (wr_hangup)
        hangup_delay <= (reg_wdata_i < `MTOR_HANGUP_MIN) ?
          `MTOR_HANGUP_MIN : reg_wdata_i;
      if (wr_tone)
        tone_digit_duration <= (reg_wdata_i < `MTOR_TONE_MIN) ?
          `MTOR_TONE_MIN : (reg_wdata_i > `MTOR_TONE_MAX) ?
          `MTOR_TONE_MAX : reg_wdata_i;
      if (wr_guard)
        escape_guard_time <= reg_wdata_i;
      if (wr_opts)
        general_options <= reg_wdata_i & `MTOR_OPT_WMASK;
      // call commands record direction, winning over a same-cycle write
      if (answer_call_cmd_i)
        general_options[`MTOR_OPT_ORIG] <= 1'b0;
      else if (originate_call_cmd_i)
        general_options[`MTOR_OPT_ORIG] <= 1'b1;
      if (wr_ans)
        answer_carrier_wait <= reg_wdata_i;
      if (wr_poll)
        status_poll_interval <= reg_wdata_i;
    end
  end

  // ****************************************
  // read port and option levels
  // ****************************************
  always @* begin
    case (reg_addr_i)
      `MTOR_REG_HANGUP: next_rdata = hangup_delay;
      `MTOR_REG_TONE: next_rdata = tone_digit_duration;
      `MTOR_REG_GUARD: next_rdata = escape_guard_time;
      `MTOR_REG_OPTIONS: next_rdata = general_options;
      `MTOR_REG_ANS_WAIT: next_rdata = answer_carrier_wait;
      `MTOR_REG_POLL: next_rdata = status_poll_interval;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= next_rdata;
    end
  end
  always @(posedge clock_i) begin
    if (rst_i) begin
      echo_en_o <= 1'b0;
      result_quiet_o <= 1'b0;
      word_resp_o <= 1'b0;
      hex_readout_o <= 1'b0;
      originate_o <= 1'b0;
    end else begin
      echo_en_o <= general_options[`MTOR_OPT_ECHO];
      result_quiet_o <= general_options[`MTOR_OPT_QUIET];
      word_resp_o <= general_options[`MTOR_OPT_WORDS];
      hex_readout_o <= general_options[`MTOR_OPT_HEX];
      originate_o <= general_options[`MTOR_OPT_ORIG];
    end
  end

  // echo only applies in command mode, never to online data
  always @(posedge clock_i) begin
    if (rst_i) begin
      echo_valid_o <= 1'b0;
      echo_char_o <= 8'h00;
    end else begin
      echo_valid_o <= rx_valid_i && !online_i &&
        general_options[`MTOR_OPT_ECHO];
      if (rx_valid_i)
        echo_char_o <= rx_char_i;
    end
  end

  // ****************************************
  // timebase, carrier and call timers
  // ****************************************
  wire ms_tick;
  mtor_div #(.DIV(MS_CYCLES)) u_ms (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tick_o(ms_tick)
  );
  reg car_s1;
  reg car_s2;
  reg car_s3;
  reg car_fall;
  reg car_rise;
  // a change counts only once the second and third stages agree
  always @(posedge clock_i) begin
    if (rst_i) begin
      car_s1 <= 1'b0;
      car_s2 <= 1'b0;
      car_s3 <= 1'b0;
      carrier_o <= 1'b0;
      car_fall <= 1'b0;
      car_rise <= 1'b0;
    end else begin
      car_s1 <= carrier_i;
      car_s2 <= car_s1;
      car_s3 <= car_s2;
      car_fall <= 1'b0;
      car_rise <= 1'b0;
      if (car_s2 == car_s3 && car_s3 != carrier_o) begin
        carrier_o <= car_s3;
        car_fall <= !car_s3;
        car_rise <= car_s3;
      end
    end
  end
  wire hang_done;
  wire ans_done;
  wire ans_stop = car_rise || carrier_o;
  mtor_delay #(.UNIT_MS(HANGUP_UNIT_MS)) u_hang (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ms_tick_i(ms_tick),
    .start_i(car_fall && in_call_i),
    .stop_i(carrier_o || !in_call_i),
    .len_i(hangup_delay),
    .busy_o(),
    .done_o(hang_done)
  );

  mtor_delay #(.UNIT_MS(ANS_UNIT_MS)) u_ans (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ms_tick_i(ms_tick),
    .start_i(answer_call_cmd_i),
    .stop_i(ans_stop && !answer_call_cmd_i),
    .len_i(answer_carrier_wait),
    .busy_o(),
    .done_o(ans_done)
  );

  always @(posedge clock_i) begin
    if (rst_i)
      on_hook_o <= 1'b0;
    else
      on_hook_o <= hang_done || ans_done;
  end

  // ****************************************
  // tone dialling
  // ****************************************
  localparam [1:0] TD_IDLE = 2'h0;
  localparam [1:0] TD_TONE = 2'h1;
  localparam [1:0] TD_GAP = 2'h2;
  reg [1:0] td_state;
  wire td_done;
  wire td_accept = (td_state == TD_IDLE) && dial_valid_i;
  wire td_go = td_accept || ((td_state == TD_TONE) && td_done);
  // the same length serves tone and gap, so one timer is reused
  mtor_delay #(.UNIT_MS(TONE_UNIT_MS)) u_tone (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ms_tick_i(ms_tick),
    .start_i(td_go),
    .stop_i(1'b0),
    .len_i(tone_digit_duration),
    .busy_o(),
    .done_o(td_done)
  );

  always @(posedge clock_i) begin
    if (rst_i) begin
      td_state <= TD_IDLE;
      tone_on_o <= 1'b0;
      tone_digit_o <= 4'h0;
      dial_ready_o <= 1'b0;
    end else begin
      case (td_state)
        TD_IDLE: begin
          dial_ready_o <= !dial_valid_i;
          if (dial_valid_i) begin
            tone_digit_o <= dial_digit_i;
            tone_on_o <= 1'b1;
            td_state <= TD_TONE;
          end
        end
        TD_TONE: begin
          if (td_done) begin
            tone_on_o <= 1'b0;
            td_state <= TD_GAP;
          end
        end
        TD_GAP: begin
          if (td_done) begin
            dial_ready_o <= 1'b1;
            td_state <= TD_IDLE;
          end
        end
        default: begin
          tone_on_o <= 1'b0;
          dial_ready_o <= 1'b0;
          td_state <= TD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // escape detection and status polling
  // ****************************************
  reg [13:0] idle_ms;
  reg [1:0] esc_cnt;
  wire [13:0] guard_ms = {6'h00, escape_guard_time} * `MTOR_GUARD_UNIT_MS;
  wire esc_enabled = (escape_char_i <= `MTOR_ESC_LIMIT);
  wire esc_match = esc_enabled && (rx_char_i == escape_char_i);
  wire esc_first = (esc_cnt == 2'h0) && (idle_ms >= guard_ms);
  wire esc_next = (esc_cnt != 2'h0) && (idle_ms <= guard_ms);
  // idle is measured in whole milliseconds since the last character
  always @(posedge clock_i) begin
    if (rst_i) begin
      idle_ms <= 14'h0000;
      esc_cnt <= 2'h0;
      escape_o <= 1'b0;
    end else begin
      escape_o <= 1'b0;
      if (rx_valid_i)
        idle_ms <= 14'h0000;
      else if (ms_tick && idle_ms != 14'h3fff)
        idle_ms <= idle_ms + 14'h0001;
      if (!online_i) begin
        esc_cnt <= 2'h0;
      end else if (rx_valid_i) begin
        if (esc_match && (esc_first || esc_next)) begin
          if (esc_cnt == `MTOR_ESC_COUNT - 2'h1) begin
            esc_cnt <= 2'h0;
            escape_o <= 1'b1;
          end else begin
            esc_cnt <= esc_cnt + 2'h1;
          end
        end else begin
          esc_cnt <= 2'h0;
        end
      end else if (esc_cnt != 2'h0 && idle_ms > guard_ms) begin
        esc_cnt <= 2'h0;
      end
    end
  end
  reg mon_q;
  wire poll_done;
  wire mon_start = status_monitor_cmd_i && !mon_q;
  // a zero interval would poll every cycle, so it counts as one
  wire [7:0] poll_len = (status_poll_interval == 8'h00) ? 8'h01 :
    status_poll_interval;

  mtor_delay #(.UNIT_MS(POLL_UNIT_MS)) u_poll (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ms_tick_i(ms_tick),
    .start_i(mon_start || (status_monitor_cmd_i && poll_done)),
    .stop_i(!status_monitor_cmd_i),
    .len_i(poll_len),
    .busy_o(),
    .done_o(poll_done)
  );

  always @(posedge clock_i) begin
    if (rst_i) begin
      mon_q <= 1'b0;
      poll_o <= 1'b0;
    end else begin
      mon_q <= status_monitor_cmd_i;
      poll_o <= mon_start || (status_monitor_cmd_i && poll_done);
    end
  end

endmodule // mtor_bank

//--- testbench/mtor_host.sv
// host terminal model that sends characters to the register bank
`timescale 1ns/1ns
module mtor_host (
  // clock
  input wire clock_i,
  // characters to the bank
  output reg rx_valid_o,
  output reg [7:0] rx_char_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o = 8'h00;
  end
  // caller sets the idle spacing before each character
  task send(input [7:0] c, input integer idle);
    begin
      repeat (idle) @(negedge clock_i);
      @(negedge clock_i);
      rx_char_o = c;
      rx_valid_o = 1'b1;
      @(negedge clock_i);
      rx_valid_o = 1'b0;
      // stale char inverted so a late sample never matches
      rx_char_o = ~c;
    end
  endtask
endmodule // mtor_host

//--- testbench/mtor_bank_asserts.sv
// port assertions for the modem timing and option register bank
`timescale 1ns/1ns
module mtor_bank_chk (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // register port
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  // call and line
  input wire answer_call_cmd_i,
  input wire in_call_i,
  input wire carrier_o,
  input wire on_hook_o,
  input wire originate_o,
  // host characters
  input wire rx_valid_i,
  input wire [7:0] rx_char_i,
  input wire online_i,
  input wire [7:0] escape_char_i,
  input wire escape_o,
  input wire echo_valid_o,
  input wire [7:0] echo_char_o,
  input wire echo_en_o,
  // dialling and polling
  input wire dial_valid_i,
  input wire dial_ready_o,
  input wire tone_on_o,
  input wire status_monitor_cmd_i,
  input wire poll_o
);
  reg [15:0] lost_cnt;
  default clocking dclk @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // bounds assume hang-up value 7 at 2 ms units of 20 cycles
  always @(posedge clock_i) begin
    if (rst_i || carrier_o || !in_call_i || on_hook_o)
      lost_cnt <= 16'h0000;
    else if (lost_cnt != 16'hffff)
      lost_cnt <= lost_cnt + 16'h0001;
  end
  sequence tone_end;
    $fell(tone_on_o);
  endsequence
  a_rsvd_reads_zero: assert property (
    reg_rd_i && reg_addr_i inside {8'h0d, [8'h0f:8'h11]} |=>
    reg_rvalid_o && reg_rdata_o == 8'h00) else $error("rsvd not zero");
  a_opt_rsvd_bits: assert property (
    reg_rd_i && reg_addr_i == 8'h0e |=> reg_rdata_o[6:4] == 3'h0)
    else $error("option bits 4-6 set");
  a_echo_char: assert property (
    rx_valid_i && !online_i && echo_en_o |=>
    echo_valid_o && echo_char_o == $past(rx_char_i)) else $error("no echo");
  a_echo_cause: assert property (
    echo_valid_o |-> $past(rx_valid_i) && !$past(online_i))
    else $error("echo without char");
  a_tone_start: assert property (
    dial_valid_i && dial_ready_o |=> tone_on_o && !dial_ready_o)
    else $error("tone not started");
  a_tone_gap: assert property (
    tone_end |-> (!dial_ready_o && !tone_on_o) [*8])
    else $error("gap cut short");
  a_hang_window: assert property (
    on_hook_o && in_call_i |-> lost_cnt >= 16'd125 && lost_cnt <= 16'd155)
    else $error("hang-up delay wrong");
  a_hang_bound: assert property (lost_cnt <= 16'd155)
    else $error("hang-up missing");
  a_esc_cause: assert property (
    escape_o |-> $past(rx_valid_i) && $past(online_i) &&
    $past(rx_char_i) == $past(escape_char_i) && escape_char_i <= 8'h7f)
    else $error("escape without cause");
  a_poll_start: assert property (
    $rose(status_monitor_cmd_i) |=> poll_o) else $error("no first poll");
  a_answer_bit: assert property (
    answer_call_cmd_i |-> ##2 !originate_o) else $error("bit 7 not answer");
endmodule // mtor_bank_chk

bind mtor_bank mtor_bank_chk u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .answer_call_cmd_i(answer_call_cmd_i),
  .in_call_i(in_call_i), .carrier_o(carrier_o), .on_hook_o(on_hook_o),
  .originate_o(originate_o), .rx_valid_i(rx_valid_i),
  .rx_char_i(rx_char_i), .online_i(online_i),
  .escape_char_i(escape_char_i), .escape_o(escape_o),
  .echo_valid_o(echo_valid_o), .echo_char_o(echo_char_o),
  .echo_en_o(echo_en_o), .dial_valid_i(dial_valid_i),
  .dial_ready_o(dial_ready_o), .tone_on_o(tone_on_o),
  .status_monitor_cmd_i(status_monitor_cmd_i), .poll_o(poll_o));

//--- testbench/tb_top.sv
// self-checking bench for the modem timing and option register bank
`timescale 1ns/1ns
module tb_top;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [7:0] reg_wdata_i = 8'h00;
  reg answer_call_cmd_i = 1'b0;
  reg originate_call_cmd_i = 1'b0;
  reg in_call_i = 1'b0;
  reg carrier_i = 1'b0;
  reg online_i = 1'b0;
  reg [7:0] escape_char_i = 8'h2b;
  reg dial_valid_i = 1'b0;
  reg [3:0] dial_digit_i = 4'h0;
  reg status_monitor_cmd_i = 1'b0;
  wire rx_valid_i, reg_rvalid_o, dial_ready_o, tone_on_o, poll_o, on_hook_o;
  wire carrier_o, escape_o, echo_valid_o, echo_en_o, result_quiet_o;
  wire word_resp_o, hex_readout_o, originate_o;
  wire [7:0] rx_char_i, reg_rdata_o, echo_char_o;
  wire [3:0] tone_digit_o;
  integer err_count, cmp_count, esc_count, i, n, k;

  initial forever #5 clock_i = ~clock_i;
  always @(negedge clock_i) if (escape_o === 1'b1) esc_count = esc_count + 1;

  mtor_host host (.clock_i(clock_i), .rx_valid_o(rx_valid_i),
    .rx_char_o(rx_char_i));
  mtor_bank #(.MS_CYCLES(10), .HANGUP_UNIT_MS(2), .TONE_UNIT_MS(1),
    .ANS_UNIT_MS(5), .POLL_UNIT_MS(2)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .answer_call_cmd_i(answer_call_cmd_i),
    .originate_call_cmd_i(originate_call_cmd_i), .in_call_i(in_call_i),
    .carrier_i(carrier_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
    .online_i(online_i), .escape_char_i(escape_char_i),
    .dial_valid_i(dial_valid_i), .dial_digit_i(dial_digit_i),
    .dial_ready_o(dial_ready_o), .tone_on_o(tone_on_o),
    .tone_digit_o(tone_digit_o), .status_monitor_cmd_i(status_monitor_cmd_i),
    .poll_o(poll_o), .on_hook_o(on_hook_o), .carrier_o(carrier_o),
    .escape_o(escape_o), .echo_valid_o(echo_valid_o),
    .echo_char_o(echo_char_o), .echo_en_o(echo_en_o),
    .result_quiet_o(result_quiet_o), .word_resp_o(word_resp_o),
    .hex_readout_o(hex_readout_o), .originate_o(originate_o));

  // ****************************************
  // checks and access tasks
  // ****************************************
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_rng(input integer v, input integer lo, input integer hi);
    begin
      cmp_count = cmp_count + 1;
      if (v < lo || v > hi) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %h exp %h..%h", $time, v, lo, hi);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      rst_i = 1'b1;
      repeat (6) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clock_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clock_i);
      reg_wr_i = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clock_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clock_i);
      reg_rd_i = 1'b0;
      chk({7'h00, reg_rvalid_o}, 8'h01);
      chk(reg_rdata_o, e);
    end
  endtask
  task opt_chk(input [7:0] e);
    chk({originate_o, 3'h0, hex_readout_o, word_resp_o, result_quiet_o,
      echo_en_o}, e);
  endtask
  task pulse_cmd(input ans);
    begin
      @(negedge clock_i);
      answer_call_cmd_i = ans;
      originate_call_cmd_i = ~ans;
      @(negedge clock_i);
      answer_call_cmd_i = 1'b0;
      originate_call_cmd_i = 1'b0;
    end
  endtask
  // bounded wait for on-hook (sel 0) or poll (sel 1)
  task wait_hi(input sel, output integer c);
    begin
      c = 0;
      while ((sel ? poll_o : on_hook_o) !== 1'b1 && c < 2000) begin
        @(negedge clock_i);
        c = c + 1;
      end
    end
  endtask
  task tone_digit(input [3:0] d);
    begin
      @(negedge clock_i);
      dial_valid_i = 1'b1;
      dial_digit_i = d;
      @(negedge clock_i);
      dial_valid_i = 1'b0;
      chk({3'h0, tone_on_o, tone_digit_o}, {4'h1, d});
      for (n = 0; tone_on_o === 1'b1 && n < 999; n = n + 1)
        @(negedge clock_i);
      chk_rng(n, 38, 56);
      for (n = 0; dial_ready_o !== 1'b1 && n < 999; n = n + 1)
        @(negedge clock_i);
      chk_rng(n, 38, 56);
    end
  endtask
  task esc_try(input [7:0] c, input integer g0, g1, g2);
    begin
      host.send(8'h61, 0);
      host.send(c, g0);
      host.send(c, g1);
      host.send(c, g2);
      repeat (4) @(negedge clock_i);
    end
  endtask
  function [7:0] rst_val(input [7:0] a);
    case (a)
      8'h0a: rst_val = 8'h07;
      8'h0b: rst_val = 8'h0a;
      8'h0c, 8'h13: rst_val = 8'h02;
      8'h0e: rst_val = 8'h85;
      8'h12: rst_val = 8'h1e;
      default: rst_val = 8'h00;
    endcase
  endfunction
  function [7:0] wr_val(input [7:0] a);
    case (a)
      8'h0a, 8'h0c, 8'h12, 8'h13: wr_val = 8'hf6;
      8'h0b: wr_val = 8'h19;
      8'h0e: wr_val = 8'h86;
      default: wr_val = 8'h00;
    endcase
  endfunction

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    #400000;
    err_count = err_count + 1;
    report_and_stop;
  end
  initial begin
    err_count = 0;
    cmp_count = 0;
    esc_count = 0;
    do_reset;
    opt_chk(8'h85);
    for (i = 9; i < 21; i = i + 1) rd(i[7:0], rst_val(i[7:0]));
    for (i = 9; i < 21; i = i + 1) wr(i[7:0], 8'hf6);
    for (i = 9; i < 21; i = i + 1) rd(i[7:0], wr_val(i[7:0]));
    opt_chk(8'h86);
    wr(8'h0a, 8'h00);
    rd(8'h0a, 8'h01);
    wr(8'h0b, 8'h03);
    rd(8'h0b, 8'h05);
    do_reset;
    rd(8'h0a, 8'h07);
    host.send(8'h41, 2);
    chk({7'h00, echo_valid_o}, 8'h01);
    chk(echo_char_o, 8'h41);
    wr(8'h0e, 8'h7c);
    host.send(8'h42, 3);
    chk({7'h00, echo_valid_o}, 8'h00);
    opt_chk(8'h0c);
    wr(8'h0e, 8'h85);
    wr(8'h12, 8'h02);
    pulse_cmd(1'b1);
    wait_hi(1'b0, n);
    chk_rng(n, 85, 110);
    opt_chk(8'h05);
    pulse_cmd(1'b0);
    repeat (2) @(negedge clock_i);
    opt_chk(8'h85);
    wr(8'h12, 8'h00);
    pulse_cmd(1'b1);
    wait_hi(1'b0, n);
    chk_rng(n, 0, 3);
    wr(8'h0b, 8'h05);
    tone_digit(4'h9);
    tone_digit(4'h3);
    carrier_i = 1'b1;
    repeat (12) @(negedge clock_i);
    chk({7'h00, carrier_o}, 8'h01);
    in_call_i = 1'b1;
    carrier_i = 1'b0;
    k = 0;
    for (i = 0; i < 260; i = i + 1) begin
      @(negedge clock_i);
      if (i == 60) carrier_i = 1'b1;
      if (on_hook_o === 1'b1) k = k + 1;
    end
    chk_rng(k, 0, 0);
    carrier_i = 1'b0;
    wait_hi(1'b0, n);
    chk_rng(n, 128, 160);
    in_call_i = 1'b0;
    online_i = 1'b1;
    esc_try(8'h2b, 1100, 100, 100);
    chk_rng(esc_count, 1, 1);
    esc_try(8'h2b, 50, 50, 50);
    chk_rng(esc_count, 1, 1);
    esc_try(8'h2b, 1100, 1200, 100);
    chk_rng(esc_count, 1, 1);
    escape_char_i = 8'h80;
    esc_try(8'h80, 1100, 100, 100);
    chk_rng(esc_count, 1, 1);
    escape_char_i = 8'h2b;
    online_i = 1'b0;
    wr(8'h13, 8'h01);
    status_monitor_cmd_i = 1'b1;
    wait_hi(1'b1, n);
    chk_rng(n, 1, 2);
    @(negedge clock_i);
    wait_hi(1'b1, n);
    chk_rng(n, 10, 21);
    status_monitor_cmd_i = 1'b0;
    report_and_stop;
  end
endmodule // tb_top
